// [logic/pss_sequencer.v]
// sample clock sequencer for a pipelined converter and an output sample path
//
// Notes on behaviour
// - a value is passed on only once the pipeline depth in further ticks has followed it.
// - a finite acquisition of n samples ends only after n plus depth pulses.
// - with the internal clock the block issues all n plus depth pulses itself.
// - single-point hardware timing is refused on pipelined variants unless supported.
// - an on-demand read on a pipelined variant bursts depth plus one pulses at full rate.
// - an on-demand read on a plain variant bursts exactly two pulses.
// - only the result of the first burst pulse is kept, the rest are dropped.
// - samples after a long pause pass through unchanged and unmarked.
// - any rate divider is accepted, with no floor on the sample rate.
// - an outside-clocked generation outputs n samples and ends on pulse n plus one.
// - the newer timing engine ends a generation on pulse n.
`timescale 1ns/1ps
`include "pss_consts.vh"
module pss_sequencer #(
  parameter [7:0] PIPE_DEPTH = `PSS_PIPE_DEPTH_DEF,
  parameter [0:0] PIPELINED = 1'b1,
  parameter [0:0] HWSP_OK = 1'b0,
  parameter [0:0] NEW_ENGINE = 1'b0
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_sample_clk,
  input wire output_sample_pulse,
  input wire pause_trig,
  output reg adc_sample_clk,
  input wire [15:0] adc_data,
  output reg dac_update,
  output wire [15:0] smp_data,
  output wire smp_valid,
  input wire smp_ready
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_OD = 3'b100;

  // all flush and burst counts follow from the two parameters
  localparam [16:0] DEPTH17 = (PIPELINED != 1'b0) ? {9'h000, PIPE_DEPTH} : 17'h00000;
  localparam [16:0] OD_LEN = (PIPELINED != 1'b0) ? (DEPTH17 + 17'h00001) : 17'h00002;
  localparam [16:0] OD_KEEP = DEPTH17 + 17'h00001;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a[7:2] == off[7:2]);
    end
  endfunction

  // pin synchronisers: bit0 ext clock, bit1 output sample pulse, bit2 pause
  wire [2:0] pin_raw;
  wire [2:0] pin_rise;
  wire [2:0] pin_lvl;
  assign pin_raw = {pause_trig, output_sample_pulse, ext_sample_clk};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg filt_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          filt_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            filt_q <= s3_q;
          end
        end
      end
      assign pin_rise[g] = s2_q & s3_q & ~filt_q;
      assign pin_lvl[g] = filt_q;
    end
  endgenerate

  reg [2:0] state_q;
  reg ext_sel_q;
  reg hwsp_q;
  reg [15:0] acq_n_q;
  reg [15:0] rate_q;
  reg [15:0] gen_n_q;
  reg [15:0] od_data_q;
  reg [15:0] div_q;
  reg [16:0] pulse_q;
  reg [16:0] total_q;
  reg cap_pend_q;
  reg acq_done_q;
  reg od_valid_q;
  reg cfg_err_q;
  reg overrun_q;
  reg gen_busy_q;
  reg gen_done_q;
  reg [16:0] gen_cnt_q;

  wire buf_ready;
  wire buf_push;
  wire rd_phase;
  wire wr_en;
  wire ctrl_wr;
  wire st_wr;
  wire mapped;
  wire reject;
  wire acq_go;
  wire od_go;
  wire gen_go;
  wire [15:0] div_lim;
  wire [15:0] period;
  wire int_ok;
  wire tick_fire;
  wire acq_end;
  wire od_end;
  wire [16:0] gen_next;
  wire gen_end;
  wire [7:0] status_w;
  reg [31:0] rdata_d;

  // apb: one wait state, writes land on the completing edge
  assign rd_phase = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign ctrl_wr = wr_en & hit(paddr, `PSS_CTRL_OFF);
  assign st_wr = wr_en & hit(paddr, `PSS_STATUS_OFF);
  assign mapped = hit(paddr, `PSS_CTRL_OFF) | hit(paddr, `PSS_ACQ_N_OFF) |
                  hit(paddr, `PSS_RATE_OFF) | hit(paddr, `PSS_GEN_N_OFF) |
                  hit(paddr, `PSS_STATUS_OFF) | hit(paddr, `PSS_OD_DATA_OFF);

  assign reject = pwdata[`PSS_CTRL_HWSP] & PIPELINED & ~HWSP_OK;
  assign acq_go = ctrl_wr & pwdata[`PSS_CTRL_ACQ_GO] & (state_q == ST_IDLE) & ~reject;
  assign od_go = ctrl_wr & pwdata[`PSS_CTRL_OD_GO] & ~pwdata[`PSS_CTRL_ACQ_GO] &
                 (state_q == ST_IDLE) & ~reject;
  assign gen_go = ctrl_wr & pwdata[`PSS_CTRL_GEN_GO] & ~gen_busy_q;

  // divider of zero or one still yields one tick per capture slot; no low-rate floor
  assign div_lim = (rate_q == 16'h0000) ? 16'h0000 : (rate_q - 16'h0001);
  assign period = `PSS_OD_PERIOD - 16'h0001;

  // internal ticks stall while the buffer is full, so no word is lost
  // pause only gates ticks; samples held across it pass unmarked
  assign int_ok = ~ext_sel_q & ~pin_lvl[2] & buf_ready & ~cap_pend_q & (div_q >= div_lim);

  always @* begin
    rdata_d = 32'h00000000;
    case (1'b1)
      hit(paddr, `PSS_CTRL_OFF): begin
        rdata_d[`PSS_CTRL_EXT_SEL] = ext_sel_q;
        rdata_d[`PSS_CTRL_HWSP] = hwsp_q;
      end
      hit(paddr, `PSS_ACQ_N_OFF): rdata_d[15:0] = acq_n_q;
      hit(paddr, `PSS_RATE_OFF): rdata_d[15:0] = rate_q;
      hit(paddr, `PSS_GEN_N_OFF): rdata_d[15:0] = gen_n_q;
      hit(paddr, `PSS_STATUS_OFF): rdata_d[7:0] = status_w;
      hit(paddr, `PSS_OD_DATA_OFF): rdata_d[15:0] = od_data_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  assign status_w = {overrun_q, cfg_err_q, od_valid_q, (state_q == ST_OD),
                     gen_done_q, gen_busy_q, acq_done_q, (state_q == ST_RUN)};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_phase;
      if (rd_phase) begin
        prdata <= pwrite ? 32'h00000000 : rdata_d;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_q <= 1'b0;
      hwsp_q <= 1'b0;
      acq_n_q <= `PSS_ACQ_N_RST;
      rate_q <= `PSS_RATE_RST;
      gen_n_q <= `PSS_GEN_N_RST;
    end else begin
      if (ctrl_wr & ~reject) begin
        ext_sel_q <= pwdata[`PSS_CTRL_EXT_SEL];
        hwsp_q <= pwdata[`PSS_CTRL_HWSP];
      end
      if (wr_en & hit(paddr, `PSS_ACQ_N_OFF)) begin
        acq_n_q <= pwdata[15:0];
      end
      if (wr_en & hit(paddr, `PSS_RATE_OFF)) begin
        rate_q <= pwdata[15:0];
      end
      if (wr_en & hit(paddr, `PSS_GEN_N_OFF)) begin
        gen_n_q <= pwdata[15:0];
      end
    end
  end

  // tick source: internal divider, outside clock, or full-rate burst
  // with the outside clock the count of pulses is up to the far side
  assign tick_fire = (state_q == ST_RUN) & (pulse_q != total_q) &
                     (ext_sel_q ? (pin_rise[0] & ~pin_lvl[2]) : int_ok) |
                     (state_q == ST_OD) & (pulse_q != total_q) & ~cap_pend_q &
                     (div_q >= period);

  assign buf_push = (state_q == ST_RUN) & cap_pend_q & (pulse_q > DEPTH17);
  assign acq_end = (state_q == ST_RUN) & cap_pend_q & (pulse_q == total_q);
  assign od_end = (state_q == ST_OD) & cap_pend_q & (pulse_q == total_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      div_q <= 16'h0000;
      pulse_q <= 17'h00000;
      total_q <= 17'h00000;
      cap_pend_q <= 1'b0;
      adc_sample_clk <= 1'b0;
      od_data_q <= 16'h0000;
    end else begin
      adc_sample_clk <= tick_fire;
      cap_pend_q <= tick_fire;
      if (tick_fire) begin
        pulse_q <= pulse_q + 17'h00001;
        div_q <= 16'h0000;
      end else if (div_q != 16'hFFFF) begin
        div_q <= div_q + 16'h0001;
      end
      case (state_q)
        ST_IDLE: begin
          pulse_q <= 17'h00000;
          div_q <= 16'h0000;
          if (acq_go) begin
            total_q <= {1'b0, acq_n_q} + DEPTH17;
            if (({1'b0, acq_n_q} + DEPTH17) != 17'h00000) begin
              state_q <= ST_RUN;
            end
          end else if (od_go) begin
            total_q <= OD_LEN;
            state_q <= ST_OD;
          end
        end
        ST_RUN: begin
          if (acq_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_OD: begin
          // the first pulse's value surfaces after depth more ticks; others drop
          if (cap_pend_q & (pulse_q == OD_KEEP)) begin
            od_data_q <= adc_data;
          end
          if (od_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_done_q <= 1'b0;
      od_valid_q <= 1'b0;
      cfg_err_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      acq_done_q <= acq_end | (acq_go & (({1'b0, acq_n_q} + DEPTH17) == 17'h00000)) |
                    (acq_done_q & ~(st_wr & pwdata[`PSS_ST_ACQ_DONE]));
      od_valid_q <= od_end | (od_valid_q & ~(st_wr & pwdata[`PSS_ST_OD_VALID]) & ~od_go);
      cfg_err_q <= (ctrl_wr & reject) | (cfg_err_q & ~(st_wr & pwdata[`PSS_ST_CFG_ERR]));
      overrun_q <= (buf_push & ~buf_ready) |
                   (overrun_q & ~(st_wr & pwdata[`PSS_ST_OVERRUN]));
    end
  end

  // generation: n updates, completion on pulse n+1, or pulse n on the newer engine
  assign gen_next = gen_cnt_q + 17'h00001;
  assign gen_end = gen_busy_q & pin_rise[1] &
                   (gen_next == ({1'b0, gen_n_q} + ((NEW_ENGINE != 1'b0) ? 17'h00000 :
                   17'h00001)));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_busy_q <= 1'b0;
      gen_done_q <= 1'b0;
      gen_cnt_q <= 17'h00000;
      dac_update <= 1'b0;
    end else begin
      dac_update <= gen_busy_q & pin_rise[1] & (gen_next <= {1'b0, gen_n_q});
      if (gen_go) begin
        gen_cnt_q <= 17'h00000;
        // the newer engine with nothing to send is done at once
        gen_busy_q <= ~((NEW_ENGINE != 1'b0) & (gen_n_q == 16'h0000));
      end else if (gen_busy_q & pin_rise[1]) begin
        gen_cnt_q <= gen_next;
        if (gen_end) begin
          gen_busy_q <= 1'b0;
        end
      end
      gen_done_q <= gen_end | (gen_go & (NEW_ENGINE != 1'b0) & (gen_n_q == 16'h0000)) |
                    (gen_done_q & ~(st_wr & pwdata[`PSS_ST_GEN_DONE]));
    end
  end

  pss_buf2 u_buf (
    .clk(pclk),
    .rst_n(presetn),
    .in_data(adc_data),
    .in_valid(buf_push),
    .in_ready(buf_ready),
    .out_data(smp_data),
    .out_valid(smp_valid),
    .out_ready(smp_ready)
  );
endmodule // pss_sequencer

// [logic/pss_consts.vh]
// constants for the pipelined sample sequencer
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// register byte offsets
`define PSS_CTRL_OFF 8'h00
`define PSS_ACQ_N_OFF 8'h04
`define PSS_RATE_OFF 8'h08
`define PSS_GEN_N_OFF 8'h0C
`define PSS_STATUS_OFF 8'h10
`define PSS_OD_DATA_OFF 8'h14

// control fields
`define PSS_CTRL_ACQ_GO 0
`define PSS_CTRL_EXT_SEL 1
`define PSS_CTRL_HWSP 2
`define PSS_CTRL_GEN_GO 3
`define PSS_CTRL_OD_GO 4

// status fields
`define PSS_ST_ACQ_BUSY 0
`define PSS_ST_ACQ_DONE 1
`define PSS_ST_GEN_BUSY 2
`define PSS_ST_GEN_DONE 3
`define PSS_ST_OD_BUSY 4
`define PSS_ST_OD_VALID 5
`define PSS_ST_CFG_ERR 6
`define PSS_ST_OVERRUN 7

// reset values
`define PSS_ACQ_N_RST 16'h0000
`define PSS_GEN_N_RST 16'h0000
`define PSS_RATE_RST 16'h0010

// design-time defaults
`define PSS_PIPE_DEPTH_DEF 8'h03

// cycles between on-demand burst pulses, the fastest rate of the tick path
`define PSS_OD_PERIOD 16'h0002

`endif

// [logic/pss_buf2.v]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pss_buf2 (
  input wire clk,
  input wire rst_n,
  input wire [15:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [15:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [15:0] skid_q;
  reg skid_v_q;
  wire push;
  wire pop;

  // ready depends only on a flop, so no combinational path runs through
  assign in_ready = ~skid_v_q;
  assign push = in_valid & ~skid_v_q;
  assign pop = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= 16'h0000;
      out_valid <= 1'b0;
      skid_q <= 16'h0000;
      skid_v_q <= 1'b0;
    end else if (pop) begin
      if (skid_v_q) begin
        out_data <= skid_q;
        skid_v_q <= 1'b0;
      end else if (push) begin
        out_data <= in_data;
      end else begin
        out_valid <= 1'b0;
      end
    end else if (push) begin
      if (!out_valid) begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end else begin
        skid_q <= in_data;
        skid_v_q <= 1'b1;
      end
    end
  end
endmodule // pss_buf2

// [tb/pss_seq_chk.sv]
// port assertions for the sample sequencer
`timescale 1ns/1ps
module pss_seq_chk #(
  parameter [7:0] PIPE_DEPTH = 8'h03
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ext_sample_clk,
  input wire output_sample_pulse,
  input wire pause_trig,
  input wire adc_sample_clk,
  input wire [15:0] adc_data,
  input wire dac_update,
  input wire [15:0] smp_data,
  input wire smp_valid,
  input wire smp_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_lat: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not after one wait state");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_req: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready without access");
  a_err_map: assert property (pready |-> pslverr == (paddr[7:2] > 6'h05))
    else $error("error flag wrong for address");
  a_wr_zero: assert property (pready && pwrite |-> prdata == 32'h00000000)
    else $error("read data not zero on write");
  a_tick_gap: assert property (adc_sample_clk |=> !adc_sample_clk)
    else $error("sample pulses too close");
  a_dac_gap: assert property (dac_update |=> !dac_update)
    else $error("output pulse too long");
  a_stream_hold: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
    else $error("stalled word changed");
  c_tick: cover property (adc_sample_clk);
  c_dac: cover property (dac_update);
  c_xfer: cover property (smp_valid && smp_ready);
  c_err: cover property (pready && pslverr);
endmodule // pss_seq_chk
bind pss_sequencer pss_seq_chk #(.PIPE_DEPTH(PIPE_DEPTH)) pss_seq_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_sample_clk(ext_sample_clk), .output_sample_pulse(output_sample_pulse),
  .pause_trig(pause_trig), .adc_sample_clk(adc_sample_clk), .adc_data(adc_data),
  .dac_update(dac_update), .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready));

// [tb/pss_far_model.sv]
// converter and outside sample clock model
`timescale 1ns/1ps
module pss_far_model #(
  parameter [15:0] DEPTH = 16'h0003
) (
  input wire pclk,
  input wire presetn,
  input wire adc_sample_clk,
  input wire [15:0] pulse_n,
  input wire pulse_go,
  output logic [15:0] adc_data,
  output logic ext_sample_clk,
  output logic output_sample_pulse,
  output logic far_busy
);
  logic [15:0] left_q;
  logic [15:0] k_q;
  logic [15:0] val;
  logic [2:0] ph_q;
  // tick k carries the sample taken depth ticks earlier
  assign val = 16'hA001 + k_q - DEPTH;
  // off the tick the bus shows the inverse, so a stale capture is caught
  assign adc_data = adc_sample_clk ? val : ~val;
  // n pulses, 4 high 4 low, line still between bursts
  assign far_busy = left_q != 16'h0000;
  assign ext_sample_clk = far_busy && ph_q[2];
  assign output_sample_pulse = ext_sample_clk;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 16'h0000;
      k_q <= 16'h0000;
      ph_q <= 3'h0;
    end else begin
      if (adc_sample_clk) k_q <= k_q + 16'h0001;
      if (pulse_go) begin
        left_q <= pulse_n;
        k_q <= 16'h0000;
        ph_q <= 3'h0;
      end else if (far_busy) begin
        ph_q <= ph_q + 3'h1;
        if (ph_q == 3'h7) left_q <= left_q - 16'h0001;
      end
    end
  end
endmodule // pss_far_model

// [tb/tb_top.sv]
// testbench for the sample sequencer
`timescale 1ns/1ps
`include "pss_consts.vh"
module tb_top;
  localparam int DEPTH = 3;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pause_trig = 0, smp_ready = 0, pulse_go = 0, err;
  logic pready, pslverr, ext_clk, out_pulse, adc_sample_clk, dac_update, smp_valid, far_busy;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] adc_data, smp_data, pulse_n = 0;
  int error_cnt = 0, samples_checked = 0, n_tick = 0, n_dac = 0, n_rx = 0;
  initial forever #12.5 pclk = ~pclk;
  pss_sequencer #(.PIPE_DEPTH(DEPTH)) pss_sequencer_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_sample_clk(ext_clk),
    .output_sample_pulse(out_pulse), .pause_trig(pause_trig), .adc_sample_clk(adc_sample_clk),
    .adc_data(adc_data), .dac_update(dac_update), .smp_data(smp_data), .smp_valid(smp_valid),
    .smp_ready(smp_ready));
  pss_far_model #(.DEPTH(DEPTH)) pss_far_model_i (.pclk(pclk), .presetn(presetn),
    .adc_sample_clk(adc_sample_clk), .pulse_n(pulse_n), .pulse_go(pulse_go),
    .adc_data(adc_data), .ext_sample_clk(ext_clk), .output_sample_pulse(out_pulse),
    .far_busy(far_busy));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task hang;
    error_cnt++;
    print_verdict;
  endtask
  // consumer stalls every other cycle; stream words come in sample order
  always @(posedge pclk) begin
    smp_ready <= ~smp_ready;
    if (adc_sample_clk === 1'b1) n_tick++;
    if (dac_update === 1'b1) n_dac++;
    if (smp_valid === 1'b1 && smp_ready) begin
      chk({16'h0000, smp_data}, 32'hA001 + n_rx);
      n_rx++;
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) hang;
  endtask
  task poll(input int b);
    int i;
    for (i = 0; i < 300; i++) begin
      apb(1'b0, `PSS_STATUS_OFF, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    if (i == 300) hang;
  endtask
  // bursts of outside pulses; n of zero only restarts the converter count
  task far(input logic [15:0] n);
    int i;
    @(posedge pclk);
    pulse_n <= n;
    pulse_go <= 1'b1;
    @(posedge pclk);
    pulse_go <= 1'b0;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (far_busy !== 1'b0 && i < 3000);
    if (i >= 3000) hang;
    repeat (8) @(posedge pclk);
  endtask
  task t_regs;
    apb(1'b0, `PSS_RATE_OFF, 32'h0);
    chk(rd, 32'h00000010);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    apb(1'b1, `PSS_RATE_OFF, 32'h00000002);
    apb(1'b0, `PSS_RATE_OFF, 32'h0);
    chk(rd, 32'h00000002);
    $display("registers done");
  endtask
  task t_acq_int;
    far(16'h0000);
    n_tick = 0;
    n_rx = 0;
    apb(1'b1, `PSS_ACQ_N_OFF, 32'h5);
    apb(1'b1, `PSS_CTRL_OFF, 32'h1);
    // short pause mid-run; words must still pass unchanged
    pause_trig <= 1'b1;
    repeat (30) @(posedge pclk);
    pause_trig <= 1'b0;
    poll(`PSS_ST_ACQ_DONE);
    // let the stalled consumer drain the buffer before counting words
    repeat (4) @(posedge pclk);
    chk(n_tick, 5 + DEPTH);
    chk(n_rx, 5);
    apb(1'b1, `PSS_STATUS_OFF, 32'h2);
    $display("internal acquisition done");
  endtask
  task t_acq_ext;
    n_tick = 0;
    n_rx = 0;
    apb(1'b1, `PSS_ACQ_N_OFF, 32'h2);
    apb(1'b1, `PSS_CTRL_OFF, 32'h2);
    apb(1'b1, `PSS_CTRL_OFF, 32'h3);
    far(16'(2 + DEPTH));
    poll(`PSS_ST_ACQ_DONE);
    repeat (4) @(posedge pclk);
    chk(n_tick, 2 + DEPTH);
    chk(n_rx, 2);
    apb(1'b1, `PSS_STATUS_OFF, 32'h2);
    apb(1'b1, `PSS_CTRL_OFF, 32'h0);
    $display("outside acquisition done");
  endtask
  task t_od;
    far(16'h0000);
    n_tick = 0;
    n_rx = 0;
    apb(1'b1, `PSS_CTRL_OFF, 32'h10);
    poll(`PSS_ST_OD_VALID);
    chk(n_tick, DEPTH + 1);
    apb(1'b0, `PSS_OD_DATA_OFF, 32'h0);
    chk(rd, 32'h0000A001);
    $display("single read done");
  endtask
  task t_hwsp;
    apb(1'b1, `PSS_CTRL_OFF, 32'h4);
    apb(1'b0, `PSS_STATUS_OFF, 32'h0);
    chk({31'h0, rd[`PSS_ST_CFG_ERR]}, 32'h1);
    apb(1'b0, `PSS_CTRL_OFF, 32'h0);
    chk({31'h0, rd[`PSS_CTRL_HWSP]}, 32'h0);
    apb(1'b1, `PSS_STATUS_OFF, 32'h40);
    $display("mode refusal done");
  endtask
  task t_gen;
    n_dac = 0;
    apb(1'b1, `PSS_GEN_N_OFF, 32'h3);
    apb(1'b1, `PSS_CTRL_OFF, 32'h8);
    far(16'h0003);
    chk(n_dac, 3);
    apb(1'b0, `PSS_STATUS_OFF, 32'h0);
    chk({31'h0, rd[`PSS_ST_GEN_DONE]}, 32'h0);
    far(16'h0001);
    poll(`PSS_ST_GEN_DONE);
    chk(n_dac, 3);
    $display("generation done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_acq_int;
    t_acq_ext;
    t_od;
    t_hwsp;
    t_gen;
    print_verdict;
  end
endmodule // tb_top
